// [core/wuf_pkg.sv]
// package: wake-up frame filter constants, types and crc helper
package wuf_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00; // wake_control_status_reg
  localparam logic [7:0] ADDR_LINK  = 8'h04; // link_control_reg
  localparam logic [7:0] ADDR_LOAD  = 8'h08; // wakeup_filter_load_port
  localparam logic [7:0] ADDR_ISTAT = 8'h0C;
  localparam logic [7:0] ADDR_IMASK = 8'h10;
  localparam logic [7:0] ADDR_INFO  = 8'h14;
  // ctrl, link and interrupt fields
  localparam int B_WAKE_EN = 0;
  localparam int B_MAGIC  = 1;
  localparam int B_RCVD   = 2;
  localparam int B_R_IRQ  = 3;
  localparam int B_R_PEV  = 4;
  localparam int B_LDRST  = 5;
  localparam int B_BCDIS  = 0;
  localparam int B_IEV    = 0;
  // ---------------------------------------------------------------
  // filter set
  // ---------------------------------------------------------------
  localparam int NFILT      = 4;
  localparam int MASK_BITS  = 31;
  localparam int LOAD_WORDS = 8;
  localparam int C_ENABLE   = 0;
  localparam int C_MCAST    = 3;
  localparam logic [2:0] W_CMD  = 3'h4;
  localparam logic [2:0] W_OFF  = 3'h5;
  localparam logic [2:0] W_CRC0 = 3'h6;
  localparam logic [2:0] W_CRC1 = 3'h7;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [10:0] CNT_MAX  = 11'h7FF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_EVAL = 2'b10
  } wuf_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       first;
    logic       last;
    logic       err;
    logic       da_station;
    logic       da_mcast;
    logic       da_brdc;
  } wuf_rx_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } wuf_fwd_t;

  // lsb-first serial crc over one byte, same bit order as the line
  function automatic logic [15:0] wuf_crc_byte(logic [15:0] c,
                                               logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int b = 0; b < 8; b++) begin
      if (x[15] ^ d[b]) begin
        x = {x[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        x = {x[14:0], 1'b0};
      end
    end
    return x;
  endfunction
endpackage

// [core/wuf_filter.sv]
// module: wake-up frame filter with apb registers
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module wuf_filter (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             power_d1,
  input  wire wuf_pkg::wuf_rx_t rx,
  output wuf_pkg::wuf_fwd_t     fwd,
  output logic                  magic_active,
  output logic                  irq,
  output logic                  power_event_output
);
  import wuf_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    wuf_state_t                       state;
    logic                             wake_en;
    logic                             magic;
    logic                             rcvd;
    logic                             r_irq;
    logic                             r_pev;
    logic                             bcdis;
    logic                             istat;
    logic                             imask;
    logic [2:0]                       ld_idx;
    logic [NFILT-1:0][MASK_BITS-1:0]  fmask;
    logic [NFILT-1:0][3:0]            fcmd;
    logic [NFILT-1:0][7:0]            foff;
    logic [NFILT-1:0][15:0]           fcrc;
    logic [NFILT-1:0][15:0]           crc;
    logic [10:0]                      cnt;
    logic                             is_mc;
    logic                             ferr;
    logic [NFILT-1:0]                 last_hit;
    logic [31:0]                      rdata;
    wuf_fwd_t                         fwd;
  } wuf_regs_t;

  wuf_regs_t        r;
  wuf_regs_t        next_r;
  logic             wake_on;
  logic             wr;
  logic             rd_setup;
  logic             mapped;
  logic [NFILT-1:0] hit;
  logic [NFILT-1:0] fen;
  logic [NFILT-1:0] fmc;
  logic             fwd_ok;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_LINK) |
                  (paddr == ADDR_LOAD) | (paddr == ADDR_ISTAT) |
                  (paddr == ADDR_IMASK) | (paddr == ADDR_INFO);
  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = r.rdata;

  assign wake_on = r.wake_en | power_d1;
  assign magic_active = r.magic | power_d1;
  assign fwd = r.fwd;
  assign irq = r.r_irq & r.istat & r.imask;
  assign power_event_output = r.r_pev & r.rcvd;

  // normal path drops broadcasts when disabled; wake mode forwards none
  assign fwd_ok = ~wake_on &
                  ~(rx.da_brdc & r.bcdis);

  // ---------------------------------------------------------------
  // filter evaluation
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NFILT; i++) begin
      fen[i] = r.fcmd[i][C_ENABLE];
      fmc[i] = r.fcmd[i][C_MCAST];
      hit[i] = r.fcmd[i][C_ENABLE] & ~r.ferr &
               (r.fcmd[i][C_MCAST] == r.is_mc) &
               (r.crc[i] == r.fcrc[i]);
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [10:0] rel;
    logic        set_ev;
    rel = 11'h000;
    set_ev = 1'b0;
    next_r = r;
    next_r.fwd.valid = 1'b0;
    next_r.fwd.last = 1'b0;

    if (rd_setup) begin
      case (paddr)
        ADDR_CTRL: next_r.rdata = {26'h0000000, 1'b0, r.r_pev,
                                   r.r_irq, r.rcvd, magic_active,
                                   wake_on};
        ADDR_LINK: next_r.rdata = {31'h00000000, r.bcdis};
        ADDR_ISTAT: next_r.rdata = {31'h00000000, r.istat};
        ADDR_IMASK: next_r.rdata = {31'h00000000, r.imask};
        ADDR_INFO: next_r.rdata = {25'h0000000, r.ld_idx, r.last_hit};
        default: next_r.rdata = 32'h00000000;
      endcase
    end

    // register writes; hardware sets below win over clears
    if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          next_r.wake_en = pwdata[B_WAKE_EN];
          next_r.magic   = pwdata[B_MAGIC];
          next_r.r_irq   = pwdata[B_R_IRQ];
          next_r.r_pev   = pwdata[B_R_PEV];
          if (pwdata[B_RCVD]) begin
            next_r.rcvd = 1'b0;
          end
          if (pwdata[B_LDRST]) begin
            next_r.ld_idx = 3'h0;
          end
        end
        ADDR_LINK: next_r.bcdis = pwdata[B_BCDIS];
        ADDR_ISTAT: begin
          if (pwdata[B_IEV]) begin
            next_r.istat = 1'b0;
          end
        end
        ADDR_IMASK: next_r.imask = pwdata[B_IEV];
        ADDR_LOAD: begin
          next_r.ld_idx = r.ld_idx + 3'h1;
          case (r.ld_idx)
            3'h0, 3'h1, 3'h2, 3'h3:
              next_r.fmask[r.ld_idx[1:0]] = pwdata[30:0];
            W_CMD: begin
              for (int i = 0; i < NFILT; i++) begin
                next_r.fcmd[i] = pwdata[8*i +: 4];
              end
            end
            W_OFF: begin
              for (int i = 0; i < NFILT; i++) begin
                next_r.foff[i] = pwdata[8*i +: 8];
              end
            end
            W_CRC0: begin
              next_r.fcrc[0] = pwdata[15:0];
              next_r.fcrc[1] = pwdata[31:16];
            end
            W_CRC1: begin
              next_r.fcrc[2] = pwdata[15:0];
              next_r.fcrc[3] = pwdata[31:16];
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // forwarding in normal reception
    if (rx.valid && fwd_ok) begin
      next_r.fwd.valid = 1'b1;
      next_r.fwd.data = rx.data;
      next_r.fwd.last = rx.last;
    end

    case (r.state)
      ST_IDLE: begin
        // every frame for the station, incl. broadcast, is examined
        if (rx.valid && rx.first && wake_on &&
            (rx.da_station | rx.da_mcast | rx.da_brdc)) begin
          next_r.is_mc = rx.da_mcast | rx.da_brdc;
          next_r.ferr = 1'b0;
          next_r.cnt = 11'h001;
          for (int i = 0; i < NFILT; i++) begin
            next_r.crc[i] = CRC_INIT;
            if (r.foff[i] == 8'h00 && r.fmask[i][0]) begin
              next_r.crc[i] = wuf_crc_byte(CRC_INIT, rx.data);
            end
          end
          next_r.state = rx.last ? ST_EVAL : ST_RECV;
          if (rx.last) begin
            next_r.ferr = rx.err;
          end
        end
      end
      ST_RECV: begin
        if (rx.valid) begin
          for (int i = 0; i < NFILT; i++) begin
            rel = r.cnt - {3'b000, r.foff[i]};
            if (r.cnt >= {3'b000, r.foff[i]} &&
                rel < 11'(MASK_BITS) &&
                r.fmask[i][rel[4:0]]) begin
              next_r.crc[i] = wuf_crc_byte(r.crc[i], rx.data);
            end
          end
          if (r.cnt != CNT_MAX) begin
            next_r.cnt = r.cnt + 11'h001;
          end
          if (rx.last) begin
            next_r.ferr = rx.err;
            next_r.state = ST_EVAL;
          end
        end
      end
      ST_EVAL: begin
        next_r.state = ST_IDLE;
        next_r.last_hit = hit;
        set_ev = |hit;
      end
      default: next_r.state = ST_IDLE;
    endcase

    if (set_ev) begin
      next_r.rcvd = 1'b1;
      next_r.istat = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence frame_end_s;
    r.state == ST_RECV && rx.valid && rx.last;
  endsequence
  sequence eval_then_idle_s;
    r.state == ST_EVAL ##1 r.state == ST_IDLE;
  endsequence

  wake_blocks_a: assert property (
    wake_on && rx.valid |=> !fwd.valid)
    else $error("frame forwarded in wake mode");
  flag_on_hit_a: assert property (
    r.state == ST_EVAL && |hit |=> r.rcvd && r.last_hit == $past(hit))
    else $error("wake flag not set after hit");
  pev_route_a: assert property (
    r.state == ST_EVAL && |hit && r.r_pev |=> power_event_output)
    else $error("power event missing");
  normal_pass_a: assert property (
    !wake_on && rx.valid && !rx.da_brdc |=>
    fwd.valid && fwd.data == $past(rx.data))
    else $error("normal reception lost");
  mask_load_a: assert property (
    wr && paddr == ADDR_LOAD && r.ld_idx == 3'h2 |=>
    r.fmask[2] == $past(pwdata[30:0]))
    else $error("mask word not stored");
  load_wrap_a: assert property (
    wr && paddr == ADDR_LOAD && r.ld_idx == 3'h7 |=> r.ld_idx == 3'h0)
    else $error("load index did not wrap");
  d1_forced_a: assert property (
    power_d1 && rd_setup && paddr == ADDR_CTRL |=> prdata[1:0] == 2'b11)
    else $error("d1 did not force detection");
  disabled_no_hit_a: assert property (
    r.state == ST_EVAL |=> (r.last_hit & ~$past(fen)) == 4'h0)
    else $error("disabled filter matched");
  eval_step_a: assert property (
    frame_end_s |=> eval_then_idle_s)
    else $error("evaluation sequence broken");

  // ---------------------------------------------------------------
  // assertions: filter load
  // ---------------------------------------------------------------
  sequence load_word_s(logic [2:0] idx);
    wr && paddr == ADDR_LOAD && r.ld_idx == idx;
  endsequence

  cmd_load_a: assert property (
    load_word_s(W_CMD) |=> r.fcmd[1] == $past(pwdata[11:8]))
    else $error("command word not stored");
  off_load_a: assert property (
    load_word_s(W_OFF) |=> r.foff[3] == $past(pwdata[31:24]))
    else $error("offset word not stored");
  crc_low_a: assert property (
    load_word_s(W_CRC0) |=> r.fcrc[0] == $past(pwdata[15:0]))
    else $error("first crc word not stored");
  crc_high_a: assert property (
    load_word_s(W_CRC1) |=> r.fcrc[3] == $past(pwdata[31:16]))
    else $error("second crc word not stored");
  load_step_a: assert property (
    wr && paddr == ADDR_LOAD |=>
    r.ld_idx == $past(r.ld_idx) + 3'h1)
    else $error("load index did not advance");

  // ---------------------------------------------------------------
  // assertions: flags and interrupt
  // ---------------------------------------------------------------
  sequence hit_eval_s;
    r.state == ST_EVAL && |hit && !wr;
  endsequence

  irq_route_a: assert property (
    hit_eval_s ##0 (r.r_irq && r.imask) |=> irq)
    else $error("interrupt missing");
  irq_clear_a: assert property (
    wr && paddr == ADDR_ISTAT && pwdata[B_IEV] &&
    !(r.state == ST_EVAL && |hit) |=> !irq)
    else $error("interrupt not cleared");
  flag_clear_a: assert property (
    wr && paddr == ADDR_CTRL && pwdata[B_RCVD] &&
    !(r.state == ST_EVAL && |hit) |=> !r.rcvd)
    else $error("received flag not cleared");
  err_no_hit_a: assert property (
    r.state == ST_EVAL && r.ferr |=> r.last_hit == 4'h0)
    else $error("bad frame matched");

  // ---------------------------------------------------------------
  // assertions: frame path and unmapped read
  // ---------------------------------------------------------------
  brd_drop_a: assert property (
    !wake_on && rx.valid && rx.da_brdc && r.bcdis |=> !fwd.valid)
    else $error("broadcast forwarded while disabled");
  brd_frame_a: assert property (
    r.state == ST_IDLE && wake_on && rx.valid && rx.first &&
    rx.da_brdc |=> r.state != ST_IDLE && r.is_mc)
    else $error("broadcast frame not examined");
  addr_type_a: assert property (
    r.state == ST_EVAL |=>
    (r.last_hit & ($past(r.is_mc) ? ~$past(fmc) : $past(fmc))) == 4'h0)
    else $error("filter matched wrong address type");
  idle_in_d0_a: assert property (
    r.state == ST_IDLE && !wake_on |=> r.state == ST_IDLE)
    else $error("frame examined outside wake mode");
  cnt_step_a: assert property (
    r.state == ST_RECV && rx.valid && r.cnt != CNT_MAX |=>
    r.cnt == $past(r.cnt) + 11'h001)
    else $error("byte counter did not advance");
  unmapped_read_a: assert property (
    rd_setup && !mapped |=> prdata == 32'h00000000)
    else $error("unmapped read returned data");
endmodule // wuf_filter
`default_nettype wire

// [test/wuf_rx_src.sv]
// partner model: mac receive path handing over one frame byte per cycle
`timescale 1ns/10ps
`default_nettype none
module wuf_rx_src #(
  parameter int FRAME_LEN = 24
) (
  input  wire logic       pclk,
  output var  wuf_pkg::wuf_rx_t rx
);
  import wuf_pkg::*;

  initial rx = '0;

  function automatic logic [7:0] fb(logic [7:0] s, int k);
    return s ^ (k[7:0] * 8'h1D);
  endfunction

  // back-to-back bytes, then one idle cycle before the next frame
  task automatic send(input logic st, mc, bc, er, input logic [7:0] s);
    for (int k = 0; k < FRAME_LEN; k++) begin
      @(posedge pclk);
      rx <= '{valid: 1'b1, data: fb(s, k), first: k == 0,
              last: k == FRAME_LEN - 1, err: er && k == FRAME_LEN - 1,
              da_station: st, da_mcast: mc, da_brdc: bc};
    end
    @(posedge pclk);
    // released data shows a fresh pattern so no stale byte can match
    rx <= '{valid: 1'b0, data: ~rx.data, default: 1'b0};
  endtask
endmodule // wuf_rx_src
`default_nettype wire

// [test/wuf_filter_bench.sv]
// testbench: wake-up frame filter driven over apb and a frame source
`timescale 1ns/10ps
`default_nettype none
module wuf_filter_bench;
  import wuf_pkg::*;
  localparam int         FLEN = 24;
  localparam logic [7:0] SA   = 8'h3C;
  localparam logic [7:0] SB   = 8'hA5;
  logic        pclk, presetn, psel, penable, pwrite, power_d1;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, magic_active, irq, pev, last_err;
  logic [31:0] w [8];
  wuf_rx_t     rx;
  wuf_fwd_t    fwd;
  int          fail_count, n_compared, fwd_n, fwd_end;

  wuf_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_d1(power_d1), .rx(rx), .fwd(fwd),
    .magic_active(magic_active), .irq(irq), .power_event_output(pev));
  wuf_rx_src #(.FRAME_LEN(FLEN)) src (.pclk(pclk), .rx(rx));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (fwd.valid === 1'b1) fwd_n++;
    if (fwd.valid === 1'b1 && fwd.last === 1'b1) fwd_end++;
  end

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; the request stands until pready is seen high, for at most 20 cycles before the test fails
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      finish_test;
    end
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // crc-16 over the masked bytes, lsb first, as the filter sees them
  function automatic logic [15:0] exp_crc(logic [30:0] m, int o,
                                          logic [7:0] s);
    logic [15:0] c;
    logic [7:0]  d;
    c = 16'hFFFF;
    for (int k = 0; k < 31; k++) begin
      d = src.fb(s, o + k);
      for (int b = 0; b < 8 && m[k]; b++) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h8005 : 16'h0000);
      end
    end
    return c;
  endfunction

  task automatic hits(input logic st, mc, bc, er, input logic [7:0] s,
                      input logic [3:0] e);
    src.send(st, mc, bc, er, s);
    repeat (4) @(posedge pclk);
    xfer(1'b0, ADDR_INFO, 32'h0, q);
    chk("filters hit", {28'h0, q[3:0]}, {28'h0, e});
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    finish_test;
  end

  initial begin
    {presetn, psel, penable, pwrite, power_d1} = 5'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    // ---------------------------------------------------------------
    // reset and filter load
    // ---------------------------------------------------------------
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, ADDR_CTRL, 32'h0, q);
    chk("ctrl after reset", q, 32'h0);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h20, q);
    // f2 disabled although its crc fits; f3 crc deliberately wrong
    w = '{32'h0000000F, 32'h00000055, 32'h00000003, 32'h00000001,
          32'h09000901, 32'h14100E0C,
          {exp_crc(31'h55, 14, SB), exp_crc(31'hF, 12, SA)},
          {~exp_crc(31'h1, 20, SA), exp_crc(31'h3, 16, SA)}};
    for (int i = 0; i < 8; i++) xfer(1'b1, ADDR_LOAD, w[i], q);
    xfer(1'b0, ADDR_INFO, 32'h0, q);
    chk("load index", {29'h0, q[6:4]}, 32'h0);
    // ---------------------------------------------------------------
    // normal reception, then wake mode
    // ---------------------------------------------------------------
    fwd_n = 0;
    fwd_end = 0;
    src.send(1'b1, 1'b0, 1'b0, 1'b0, SA);
    repeat (2) @(posedge pclk);
    chk("forwarded bytes", fwd_n, FLEN);
    chk("forwarded ends", fwd_end, 32'h1);
    xfer(1'b1, ADDR_IMASK, 32'h1, q);
    xfer(1'b1, ADDR_CTRL, 32'h19, q);
    fwd_n = 0;
    hits(1'b1, 1'b0, 1'b0, 1'b0, SA, 4'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("power event", {31'h0, pev}, 32'h1);
    chk("suppressed bytes", fwd_n, 32'h0);
    xfer(1'b0, ADDR_CTRL, 32'h0, q);
    chk("received flag", {31'h0, q[2]}, 32'h1);
    xfer(1'b1, ADDR_CTRL, 32'h1D, q);
    xfer(1'b1, ADDR_ISTAT, 32'h1, q);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    chk("event cleared", {31'h0, pev}, 32'h0);
    xfer(1'b1, ADDR_LINK, 32'h1, q);
    hits(1'b0, 1'b0, 1'b1, 1'b0, SB, 4'h2);
    hits(1'b1, 1'b0, 1'b0, 1'b0, SB, 4'h0);
    hits(1'b1, 1'b0, 1'b0, 1'b1, SA, 4'h0);
    // ---------------------------------------------------------------
    // leave wake mode, then low-power state, then a bad address
    // ---------------------------------------------------------------
    xfer(1'b1, ADDR_CTRL, 32'h0, q);
    fwd_n = 0;
    fwd_end = 0;
    src.send(1'b0, 1'b0, 1'b1, 1'b0, SB);
    src.send(1'b1, 1'b0, 1'b0, 1'b0, SA);
    repeat (2) @(posedge pclk);
    chk("bytes after wake", fwd_n, FLEN);
    chk("ends after wake", fwd_end, 32'h1);
    power_d1 <= 1'b1;
    xfer(1'b1, ADDR_CTRL, 32'h0, q);
    xfer(1'b0, ADDR_CTRL, 32'h0, q);
    chk("forced enables", {30'h0, q[1:0]}, 32'h3);
    chk("magic active", {31'h0, magic_active}, 32'h1);
    hits(1'b1, 1'b0, 1'b0, 1'b0, SA, 4'h1);
    power_d1 <= 1'b0;
    xfer(1'b0, ADDR_CTRL, 32'h0, q);
    chk("enables in d0", {30'h0, q[1:0]}, 32'h0);
    xfer(1'b0, 8'h40, 32'h0, q);
    chk("unmapped error", {31'h0, last_err}, 32'h1);
    chk("unmapped data", q, 32'h0);
    finish_test;
  end
endmodule // wuf_filter_bench
`default_nettype wire
